// ---- cpl_pkg.sv ----
package cpl_pkg;

    // configuration scheme chosen by the mode strap
    typedef enum logic [1:0] {
        MODE_PASSIVE_SERIAL,
        MODE_FAST_PARALLEL,
        MODE_ACTIVE_SERIAL
    } cpl_mode_t;

    // loader sequence
    typedef enum logic [2:0] {
        ST_WAIT,
        ST_CMD,
        ST_LOAD,
        ST_DONE,
        ST_USER
    } cpl_state_t;

    // system clock and the clock driven out in active serial mode
    localparam int CLK_PERIOD_NS   = 10;
    localparam int AS_DCLK_HALF_NS = 40;
    localparam int AS_DCLK_HALF_CYC =
        (AS_DCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
        (AS_DCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // field widths
    localparam int DATA_W       = 8;
    localparam int UPPER_W      = 7;
    localparam int DIV_W        = 8;
    localparam int CMD_W        = 32;
    localparam int CMD_CNT_W    = 6;
    localparam int BYTE_CNT_W   = 16;
    localparam int BIT_CNT_W    = 3;
    localparam int SYNC_W       = 12;

    // read command with start address, shifted out msb first
    localparam logic [CMD_W-1:0]      AS_READ_CMD   = 32'h03000000;
    localparam logic [CMD_CNT_W-1:0]  AS_CMD_BITS   = 6'h20;
    localparam logic [DIV_W-1:0]      AS_DIV_LAST   = 8'(AS_DCLK_HALF_CYC - 1);
    localparam logic [BIT_CNT_W-1:0]  BIT_CNT_LAST  = 3'h7;

    // default image length in bytes
    localparam int IMAGE_BYTES_DEF = 64;

    // reset values
    localparam logic [DIV_W-1:0]      DIV_RST       = 8'h00;
    localparam logic [CMD_CNT_W-1:0]  CMD_CNT_RST   = 6'h00;
    localparam logic [BYTE_CNT_W-1:0] BYTE_CNT_RST  = 16'h0000;
    localparam logic [BIT_CNT_W-1:0]  BIT_CNT_RST   = 3'h0;
    localparam logic [DATA_W-1:0]     DATA_RST      = 8'h00;
    localparam logic [UPPER_W-1:0]    UPPER_RST     = 7'h00;
    localparam logic [SYNC_W-1:0]     SYNC_RST      = 12'h001;

endpackage : cpl_pkg

// ---- cpl_sync.sv ----
`timescale 1ns/1ns
`default_nettype none

module cpl_sync (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      clkEn,
    // pins in, synchronised copy out
    input  wire logic [cpl_pkg::SYNC_W-1:0] asyncIn,
    output logic      [cpl_pkg::SYNC_W-1:0] syncOut
);
    import cpl_pkg::*;

    typedef struct packed {
        logic [SYNC_W-1:0] first;
        logic [SYNC_W-1:0] second;
    } cpl_sync_st_t;

    cpl_sync_st_t st_r;
    cpl_sync_st_t st_nxt;

    // first stage feeds only the second stage
    always_comb begin
        st_nxt        = st_r;
        st_nxt.first  = asyncIn;
        st_nxt.second = st_r.first;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '{first: SYNC_RST, second: SYNC_RST};
        end else if (clkEn) begin
            st_r <= st_nxt;
        end
    end

    assign syncOut = st_r.second;

endmodule : cpl_sync
`default_nettype wire

// ---- cpl_deser.sv ----
`timescale 1ns/1ns
`default_nettype none

module cpl_deser (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      clkEn,
    // capture control
    input  wire logic                      clear,
    input  wire logic                      capture,
    input  wire logic                      parallel,
    input  wire logic                      bitIn,
    input  wire logic [cpl_pkg::DATA_W-1:0] byteIn,
    // assembled byte
    output logic      [cpl_pkg::DATA_W-1:0] byteOut,
    output logic                           byteValid
);
    import cpl_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0]    shift;
        logic [BIT_CNT_W-1:0] bitCnt;
        logic [DATA_W-1:0]    word;
        logic                 valid;
    } cpl_deser_st_t;

    cpl_deser_st_t st_r;
    cpl_deser_st_t st_nxt;

    // one bit per capture lsb first, or a whole byte per capture
    always_comb begin
        st_nxt       = st_r;
        st_nxt.valid = 1'b0;
        if (clear) begin
            st_nxt.bitCnt = BIT_CNT_RST;
        end else if (capture) begin
            if (parallel) begin
                st_nxt.word  = byteIn;
                st_nxt.valid = 1'b1;
            end else begin
                st_nxt.shift  = {bitIn, st_r.shift[DATA_W-1:1]};
                st_nxt.bitCnt = st_r.bitCnt + 3'h1;
                if (st_r.bitCnt == BIT_CNT_LAST) begin
                    st_nxt.word  = {bitIn, st_r.shift[DATA_W-1:1]};
                    st_nxt.valid = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '{shift: DATA_RST, bitCnt: BIT_CNT_RST, word: DATA_RST, valid: 1'b0};
        end else if (clkEn) begin
            st_r <= st_nxt;
        end
    end

    assign byteOut   = st_r.word;
    assign byteValid = st_r.valid;

endmodule : cpl_deser
`default_nettype wire

// ---- cpl_loader.sv ----
`timescale 1ns/1ns
`default_nettype none

// How it works
// - configuration is taken only while the chip-enable pin reads low
// - chain-enable pin is released until loading ends, then driven low
// - chain-enable feeds the next device's chip-enable; last one floats
// - in user mode the chain-enable pin follows the user pin setting
// - active serial mode shifts a read command out to the memory
// - active serial mode drives the memory select low for the transfer
// - passive modes take the external clock and capture on its rising edge
// - active serial mode drives the configuration clock out itself
// - after configuration active serial holds its driven clock low; in every mode pin clock toggles are ignored
// - serial modes move one bit per clock on the serial data pin
// - fast parallel moves one byte per clock, serial pin as bit zero
// - serial schemes keep the upper seven data pins tri-stated while loading
// - once user mode is entered the upper data pins become user I/O in every scheme
// - load-complete flag is held low until all data arrives, then released
module cpl_loader #(
    parameter int IMAGE_BYTES = cpl_pkg::IMAGE_BYTES_DEF
) (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic                        clkEn,
    // mode strap
    input  wire cpl_pkg::cpl_mode_t          cfgMode,
    // chip enable and chain enable
    input  wire logic                        chipEnableInN,
    output logic                             chainEnableOutNOut,
    output logic                             chainEnableOutNOe,
    // configuration clock pin
    input  wire logic                        dclkIn,
    output logic                             dclkOut,
    output logic                             dclkOe,
    // data pins
    input  wire logic                        serialCfgBit,
    input  wire logic [cpl_pkg::UPPER_W-1:0] dataUpperIn,
    output logic      [cpl_pkg::UPPER_W-1:0] dataUpperOut,
    output logic      [cpl_pkg::UPPER_W-1:0] dataUpperOe,
    // serial memory control
    output logic                             serialCmdOut,
    output logic                             serialCmdOe,
    output logic                             memorySelectOutN,
    output logic                             memorySelectOe,
    // load-complete pin
    output logic                             loadCompleteFlagOut,
    output logic                             loadCompleteFlagOe,
    // core side: user-mode entry and shared pin settings
    input  wire logic                        userModeStart,
    input  wire logic                        userChainOut,
    input  wire logic                        userChainOe,
    input  wire logic [cpl_pkg::UPPER_W-1:0] userUpperOut,
    input  wire logic [cpl_pkg::UPPER_W-1:0] userUpperOe,
    // core side: configuration byte stream
    output logic      [cpl_pkg::DATA_W-1:0]  cfgByte,
    output logic                             cfgByteValid,
    output logic                             userMode
);
    import cpl_pkg::*;

    localparam logic [BYTE_CNT_W-1:0] BYTE_LAST = BYTE_CNT_W'(IMAGE_BYTES - 1);

    typedef struct packed {
        cpl_state_t            state;
        cpl_mode_t             mode;
        logic [DIV_W-1:0]      divCnt;
        logic                  dclkPrev;
        logic [CMD_W-1:0]      cmdShift;
        logic [CMD_CNT_W-1:0]  cmdCnt;
        logic [BYTE_CNT_W-1:0] byteCnt;
        logic                  chainOut;
        logic                  chainOe;
        logic                  dclkOut;
        logic                  dclkOe;
        logic [UPPER_W-1:0]    upperOut;
        logic [UPPER_W-1:0]    upperOe;
        logic                  cmdOut;
        logic                  cmdOe;
        logic                  selOutN;
        logic                  selOe;
        logic                  doneOe;
        logic [DATA_W-1:0]     cfgByte;
        logic                  cfgValid;
        logic                  userMode;
    } cpl_st_t;

    cpl_st_t st_r;
    cpl_st_t st_nxt;

    // synchronised pin copies
    logic [SYNC_W-1:0]  pinSync;
    logic               ceNSync;
    logic               dclkSync;
    logic               bitSync;
    logic [UPPER_W-1:0] upperSync;
    cpl_mode_t          modeSync;

    // capture path into the deserialiser
    logic               capture;
    logic               deserClear;
    logic               parallel;
    logic [DATA_W-1:0]  asmByte;
    logic               asmValid;

    // every pin input passes two flops before use
    cpl_sync u_sync (
        .clk     (clk),
        .rst     (rst),
        .clkEn   (clkEn),
        .asyncIn ({2'(cfgMode), dataUpperIn, serialCfgBit, dclkIn, chipEnableInN}),
        .syncOut (pinSync)
    );

    assign ceNSync   = pinSync[0];
    assign dclkSync  = pinSync[1];
    assign bitSync   = pinSync[2];
    assign upperSync = pinSync[9:3];
    assign modeSync  = cpl_mode_t'(pinSync[11:10]);

    // byte assembly for serial and parallel schemes
    cpl_deser u_deser (
        .clk       (clk),
        .rst       (rst),
        .clkEn     (clkEn),
        .clear     (deserClear),
        .capture   (capture),
        .parallel  (parallel),
        .bitIn     (bitSync),
        .byteIn    ({upperSync, bitSync}),
        .byteOut   (asmByte),
        .byteValid (asmValid)
    );

    // capture strobe: rising edge of the pin clock, or of our own clock in active serial
    always_comb begin
        parallel   = (st_r.mode == MODE_FAST_PARALLEL);
        deserClear = (st_r.state != ST_LOAD);
        capture    = 1'b0;
        if (st_r.state == ST_LOAD && !ceNSync) begin
            if (st_r.mode == MODE_ACTIVE_SERIAL) begin
                capture = !st_r.dclkOut && (st_r.divCnt == AS_DIV_LAST);
            end else begin
                capture = dclkSync && !st_r.dclkPrev;
            end
        end
    end

    // loader sequence and pin drive
    always_comb begin
        st_nxt          = st_r;
        st_nxt.dclkPrev = dclkSync;
        st_nxt.cfgValid = 1'b0;

        // active serial clock divider runs while reading the memory
        if (st_r.selOe && !st_r.selOutN) begin
            if (st_r.divCnt == AS_DIV_LAST) begin
                st_nxt.divCnt  = DIV_RST;
                st_nxt.dclkOut = !st_r.dclkOut;
            end else begin
                st_nxt.divCnt = st_r.divCnt + 8'h01;
            end
        end

        // assembled bytes go out to the core and are counted
        if (asmValid) begin
            st_nxt.cfgByte  = asmByte;
            st_nxt.cfgValid = 1'b1;
            st_nxt.byteCnt  = st_r.byteCnt + 16'h0001;
        end

        unique case (st_r.state)
            ST_WAIT: begin
                st_nxt.mode     = modeSync;
                st_nxt.byteCnt  = BYTE_CNT_RST;
                st_nxt.divCnt   = DIV_RST;
                st_nxt.dclkOut  = 1'b0;
                st_nxt.chainOe  = 1'b0;
                st_nxt.doneOe   = 1'b1;
                st_nxt.upperOe  = UPPER_RST;
                st_nxt.selOutN  = 1'b1;
                st_nxt.cmdOut   = 1'b1;
                st_nxt.dclkOe   = (modeSync == MODE_ACTIVE_SERIAL);
                st_nxt.cmdOe    = (modeSync == MODE_ACTIVE_SERIAL);
                st_nxt.selOe    = (modeSync == MODE_ACTIVE_SERIAL);
                if (!ceNSync) begin
                    if (modeSync == MODE_ACTIVE_SERIAL) begin
                        st_nxt.state    = ST_CMD;
                        st_nxt.selOutN  = 1'b0;
                        st_nxt.cmdShift = {AS_READ_CMD[CMD_W-2:0], 1'b0};
                        st_nxt.cmdOut   = AS_READ_CMD[CMD_W-1];
                        st_nxt.cmdCnt   = CMD_CNT_RST;
                    end else begin
                        st_nxt.state = ST_LOAD;
                    end
                end
            end
            ST_CMD: begin
                // command bits change on the falling edge of the driven clock
                if (st_r.dclkOut && st_r.divCnt == AS_DIV_LAST) begin
                    if (st_r.cmdCnt == AS_CMD_BITS - 6'h01) begin
                        st_nxt.state  = ST_LOAD;
                        st_nxt.cmdOut = 1'b1;
                    end else begin
                        st_nxt.cmdOut   = st_r.cmdShift[CMD_W-1];
                        st_nxt.cmdShift = {st_r.cmdShift[CMD_W-2:0], 1'b0};
                    end
                    st_nxt.cmdCnt = st_r.cmdCnt + 6'h01;
                end
                if (ceNSync) begin
                    st_nxt.state = ST_WAIT;
                end
            end
            ST_LOAD: begin
                if (asmValid && st_r.byteCnt == BYTE_LAST) begin
                    st_nxt.state   = ST_DONE;
                    st_nxt.doneOe  = 1'b0;
                    st_nxt.chainOe = 1'b1;
                    st_nxt.chainOut = 1'b0;
                    st_nxt.selOutN = 1'b1;
                    st_nxt.dclkOut = 1'b0;
                    st_nxt.divCnt  = DIV_RST;
                end else if (ceNSync) begin
                    st_nxt.state = ST_WAIT;
                end
            end
            ST_DONE: begin
                // pin clock toggles are no longer looked at
                if (userModeStart) begin
                    st_nxt.state    = ST_USER;
                    st_nxt.userMode = 1'b1;
                end
            end
            ST_USER: begin
                st_nxt.chainOut = userChainOut;
                st_nxt.chainOe  = userChainOe;
                st_nxt.upperOut = userUpperOut;
                st_nxt.upperOe  = userUpperOe;
            end
        endcase

        // upper data pins never drive before user mode
        if (st_nxt.state != ST_USER) begin
            st_nxt.upperOe = UPPER_RST;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '{
                state:    ST_WAIT,
                mode:     MODE_PASSIVE_SERIAL,
                divCnt:   DIV_RST,
                dclkPrev: 1'b0,
                cmdShift: AS_READ_CMD,
                cmdCnt:   CMD_CNT_RST,
                byteCnt:  BYTE_CNT_RST,
                chainOut: 1'b0,
                chainOe:  1'b0,
                dclkOut:  1'b0,
                dclkOe:   1'b0,
                upperOut: UPPER_RST,
                upperOe:  UPPER_RST,
                cmdOut:   1'b1,
                cmdOe:    1'b0,
                selOutN:  1'b1,
                selOe:    1'b0,
                doneOe:   1'b1,
                cfgByte:  DATA_RST,
                cfgValid: 1'b0,
                userMode: 1'b0
            };
        end else if (clkEn) begin
            st_r <= st_nxt;
        end
    end

    // pins and core outputs straight from state
    assign chainEnableOutNOut  = st_r.chainOut;
    assign chainEnableOutNOe   = st_r.chainOe;
    assign dclkOut             = st_r.dclkOut;
    assign dclkOe              = st_r.dclkOe;
    assign dataUpperOut        = st_r.upperOut;
    assign dataUpperOe         = st_r.upperOe;
    assign serialCmdOut        = st_r.cmdOut;
    assign serialCmdOe         = st_r.cmdOe;
    assign memorySelectOutN    = st_r.selOutN;
    assign memorySelectOe      = st_r.selOe;
    assign loadCompleteFlagOut = 1'b0 & st_r.doneOe;   // open drain: only ever pulls low
    assign loadCompleteFlagOe  = st_r.doneOe;
    assign cfgByte             = st_r.cfgByte;
    assign cfgByteValid        = st_r.cfgValid;
    assign userMode            = st_r.userMode;

    // the serial data pin has no output path at all

endmodule : cpl_loader
`default_nettype wire

// ---- cpl_chk.sv ----
`timescale 1ns/1ns
`default_nettype none

module cpl_chk
    import cpl_pkg::*;
(
    // clock and reset
    input wire logic                        clk,
    input wire logic                        rst,
    // strap and chip enable
    input wire cpl_pkg::cpl_mode_t          cfgMode,
    input wire logic                        chipEnableInN,
    // pins driven by the loader
    input wire logic                        chainEnableOutNOut,
    input wire logic                        chainEnableOutNOe,
    input wire logic                        dclkOut,
    input wire logic                        dclkOe,
    input wire logic [cpl_pkg::UPPER_W-1:0] dataUpperOut,
    input wire logic [cpl_pkg::UPPER_W-1:0] dataUpperOe,
    input wire logic                        serialCmdOut,
    input wire logic                        serialCmdOe,
    input wire logic                        memorySelectOutN,
    input wire logic                        memorySelectOe,
    input wire logic                        loadCompleteFlagOe,
    // core side
    input wire logic                        userModeStart,
    input wire logic                        userChainOut,
    input wire logic                        userChainOe,
    input wire logic [cpl_pkg::UPPER_W-1:0] userUpperOut,
    input wire logic [cpl_pkg::UPPER_W-1:0] userUpperOe,
    input wire logic                        cfgByteValid,
    input wire logic                        userMode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // pin direction and release while loading
    upper_tristate_a: assert property (!userMode |-> dataUpperOe == 7'h00)
        else $error("upper data pins driven before user mode");
    chain_released_a: assert property (loadCompleteFlagOe |-> !chainEnableOutNOe)
        else $error("chain enable driven before load complete");
    chain_low_a: assert property ($fell(loadCompleteFlagOe) |-> chainEnableOutNOe && !chainEnableOutNOut)
        else $error("chain enable not pulled low at load complete");
    clock_dir_a: assert property (dclkOe |-> cfgMode == MODE_ACTIVE_SERIAL)
        else $error("clock pin driven outside active serial mode");
    select_active_a: assert property (!memorySelectOutN |-> memorySelectOe && dclkOe && serialCmdOe)
        else $error("memory selected without active serial pins driven");
    cmd_idle_a: assert property (memorySelectOutN |-> serialCmdOut)
        else $error("command line not idle while memory deselected");
    // behaviour once loading is over, and with chip enable held high
    clock_idle_a: assert property (!loadCompleteFlagOe |=> !dclkOut)
        else $error("clock pin not inactive after configuration");
    done_quiet_a: assert property (!loadCompleteFlagOe && !$fell(loadCompleteFlagOe) |-> !cfgByteValid)
        else $error("byte accepted after configuration");
    refused_ce_a: assert property (chipEnableInN [*8] |-> !cfgByteValid)
        else $error("byte accepted with chip enable high");
    user_entry_a: assert property (userModeStart && !loadCompleteFlagOe && !userMode |=> userMode)
        else $error("user mode not entered");
    chain_user_a: assert property (userMode && $past(userMode) |->
        chainEnableOutNOut == $past(userChainOut) && chainEnableOutNOe == $past(userChainOe))
        else $error("chain pin does not follow user setting");
    upper_user_a: assert property (userMode && $past(userMode) |->
        dataUpperOut == $past(userUpperOut) && dataUpperOe == $past(userUpperOe))
        else $error("upper data pins do not follow user setting");
endmodule : cpl_chk

bind cpl_loader cpl_chk i_chk (.*);

`default_nettype wire

// ---- cpl_partner.sv ----
`timescale 1ns/1ns
`default_nettype none

module cpl_partner
    import cpl_pkg::*;
(
    // strap and image held by the far side
    input  wire cpl_pkg::cpl_mode_t cfgMode,
    input  wire logic [31:0]        image,
    // active serial pins from the device
    input  wire logic               dclkOut,
    input  wire logic               memorySelectOutN,
    input  wire logic               serialCmdOut,
    // pins toward the device
    output logic                    dclkPin,
    output logic                    dataBit,
    output logic [6:0]              dataUpper,
    output logic [31:0]             cmdWord
);
    logic hostBit;
    logic memBit;
    int   edgeCnt;

    // idle host: clock static low, data undefined pattern
    initial begin
        hostBit = 1'b1;
        memBit = 1'b1;
        dclkPin = 1'b0;
        dataUpper = 7'h55;
        cmdWord = 32'h00000000;
        edgeCnt = 0;
    end

    // memory: first 32 selected clock rises carry the command
    always @(negedge memorySelectOutN) edgeCnt = 0;
    always @(posedge dclkOut) begin
        if (!memorySelectOutN) begin
            if (edgeCnt < 32) cmdWord = {cmdWord[30:0], serialCmdOut};
            edgeCnt = edgeCnt + 1;
        end
    end
    // memory: next data bit after each falling clock, lsb first
    always @(negedge dclkOut) begin
        if (!memorySelectOutN && edgeCnt >= 32 && edgeCnt < 64) memBit = image[edgeCnt-32];
        else memBit = ~memBit;
    end
    // deselected memory leaves the pulled-up line high
    assign dataBit = (cfgMode == MODE_ACTIVE_SERIAL) ? (memorySelectOutN ? 1'b1 : memBit) : hostBit;

    // host: one byte per call, serial lsb first or all eight pins
    task automatic host_byte(input logic [7:0] b, input logic par);
        int n;
        #3;
        n = par ? 1 : 8;
        for (int i = 0; i < n; i++) begin
            hostBit = b[i];
            dataUpper = par ? b[7:1] : ~dataUpper;
            #80 dclkPin = 1'b1;
            #80 dclkPin = 1'b0;
            hostBit = ~hostBit;
            dataUpper = ~dataUpper;
        end
    endtask : host_byte

    // host toggling the clock after configuration, which must be ignored
    task automatic host_toggle(input int n);
        for (int i = 0; i < n; i++) begin
            #80 dclkPin = 1'b1;
            #80 dclkPin = 1'b0;
        end
    endtask : host_toggle
endmodule : cpl_partner

`default_nettype wire

// ---- cpl_tb.sv ----
`timescale 1ns/1ns
`default_nettype none

`define CHECK_EQ(nm, e, a) begin check_count++; if ((e) !== (a)) begin err_count++; \
    $display("unexpected %s: expected %h, seen %h", nm, e, a); end end

module testbench;
    import cpl_pkg::*;
    localparam int NB = 4;
    logic        clk, rst, ceN, ums, uco, uce;
    cpl_mode_t   mode;
    logic [6:0]  uuo, uuoe, upOut, upOe, hostUp;
    logic [7:0]  cfgByte;
    logic [31:0] image, cmdWord;
    logic        dclkPin, dclkOut, dclkOe, dataBit, chOut, chOe, cmdOut, cmdOe, selN, selOe;
    logic        lcOut, lcOe, valid, userMode;
    logic [7:0]  got[$];
    int          err_count, check_count;
    // wire levels from all drivers
    wire logic       dclkWire = dclkOe ? dclkOut : dclkPin;
    wire logic [6:0] upPin = (upOe & upOut) | (~upOe & hostUp);

    cpl_loader #(.IMAGE_BYTES(NB)) i_dut (.clk(clk), .rst(rst), .clkEn(1'b1), .cfgMode(mode),
        .chipEnableInN(ceN), .chainEnableOutNOut(chOut), .chainEnableOutNOe(chOe), .dclkIn(dclkWire),
        .dclkOut(dclkOut), .dclkOe(dclkOe), .serialCfgBit(dataBit), .dataUpperIn(upPin),
        .dataUpperOut(upOut), .dataUpperOe(upOe), .serialCmdOut(cmdOut), .serialCmdOe(cmdOe),
        .memorySelectOutN(selN), .memorySelectOe(selOe), .loadCompleteFlagOut(lcOut),
        .loadCompleteFlagOe(lcOe), .userModeStart(ums), .userChainOut(uco), .userChainOe(uce),
        .userUpperOut(uuo), .userUpperOe(uuoe), .cfgByte(cfgByte), .cfgByteValid(valid), .userMode(userMode));
    cpl_partner i_part (.cfgMode(mode), .image(image), .dclkOut(dclkOut), .memorySelectOutN(selN),
        .serialCmdOut(cmdOut), .dclkPin(dclkPin), .dataBit(dataBit), .dataUpper(hostUp), .cmdWord(cmdWord));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // collect every byte handed to the core
    always @(posedge clk) if (valid === 1'b1) got.push_back(cfgByte);

    function automatic logic [7:0] exp_byte(input logic [31:0] img, input int i);
        return img[8*i +: 8];
    endfunction : exp_byte

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    task automatic do_reset(input cpl_mode_t m);
        image = $urandom();
        @(posedge clk);
        rst <= 1'b1;
        mode <= m;
        ceN <= 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        got.delete();
    endtask : do_reset

    task automatic wait_done(input int lim);
        int n;
        n = 0;
        while (lcOe !== 1'b0 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= lim) begin
            err_count++;
            $display("unexpected load complete: timeout");
            end_of_test();
        end
        repeat (2) @(posedge clk);
    endtask : wait_done

    task automatic check_image();
        `CHECK_EQ("byte count", NB, got.size())
        for (int i = 0; i < got.size() && i < NB; i++) `CHECK_EQ("cfgByte", exp_byte(image, i), got[i])
    endtask : check_image

    task automatic send_image(input logic par);
        for (int i = 0; i < NB; i++) i_part.host_byte(exp_byte(image, i), par);
    endtask : send_image

    task automatic enter_user();
        @(posedge clk);
        uco <= 1'($urandom());
        uce <= 1'b1;
        uuo <= 7'($urandom());
        uuoe <= 7'($urandom());
        ums <= 1'b1;
        @(posedge clk);
        ums <= 1'b0;
        repeat (3) @(posedge clk);
        `CHECK_EQ("userMode", 1'b1, userMode)
        `CHECK_EQ("chain pin", uco, chOut)
        `CHECK_EQ("chain enable", uce, chOe)
        `CHECK_EQ("upper out", uuo, upOut)
        `CHECK_EQ("upper enable", uuoe, upOe)
    endtask : enter_user

    initial begin
        rst = 1'b1;
        mode = MODE_PASSIVE_SERIAL;
        {ceN, ums, uco, uce, uuo, uuoe, image} = '0;
        err_count = 0;
        check_count = 0;
        void'($urandom(71));
        // passive serial load, then clock toggles that must be ignored
        do_reset(MODE_PASSIVE_SERIAL);
        send_image(1'b0);
        wait_done(400);
        check_image();
        `CHECK_EQ("chain enable", 1'b1, chOe)
        `CHECK_EQ("chain pin", 1'b0, chOut)
        `CHECK_EQ("upper enable", 7'h00, upOe)
        `CHECK_EQ("clock enable", 1'b0, dclkOe)
        i_part.host_toggle(6);
        repeat (12) @(posedge clk);
        `CHECK_EQ("bytes after done", NB, got.size())
        // chip enable high mid-load refuses data and restarts the count
        do_reset(MODE_PASSIVE_SERIAL);
        for (int i = 0; i < 2; i++) i_part.host_byte(exp_byte(image, i), 1'b0);
        @(posedge clk);
        ceN <= 1'b1;
        i_part.host_byte(8'ha5, 1'b0);
        repeat (8) @(posedge clk);
        `CHECK_EQ("bytes while disabled", 2, got.size())
        `CHECK_EQ("load flag", 1'b1, lcOe)
        ceN <= 1'b0;
        repeat (4) @(posedge clk);
        got.delete();
        send_image(1'b0);
        wait_done(400);
        check_image();
        // fast parallel with all-zero and all-one bytes
        do_reset(MODE_FAST_PARALLEL);
        image = {8'hff, image[23:8], 8'h00};
        send_image(1'b1);
        wait_done(400);
        check_image();
        enter_user();
        // active serial from the memory model
        do_reset(MODE_ACTIVE_SERIAL);
        wait_done(2000);
        `CHECK_EQ("read command", AS_READ_CMD, cmdWord)
        check_image();
        `CHECK_EQ("memory select", 1'b1, selN)
        `CHECK_EQ("clock after done", 1'b0, dclkOut)
        `CHECK_EQ("clock enable", 1'b1, dclkOe)
        `CHECK_EQ("load flag pin", 1'b0, lcOut)
        enter_user();
        end_of_test();
    end
endmodule : testbench

`default_nettype wire
